// ---- rtl/rfc_consts.svh ----
// Purpose: register indices, field positions and reset values
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH
`define RFC_IDX_RC 16'hFFAC
`define RFC_IDX_TCS 16'hFFAD
`define RFC_IDX_CNT 16'hFFAE
`define RFC_IDX_COR 16'hFFAF
`define RFC_RC_RST 8'h02
`define RFC_CNT_RST 8'h00
`define RFC_COR_RST 8'hFF
`define RFC_CKS_RST 3'h0
`define RFC_TCS_LOW 3'h7
`define RFC_RC_SRF 7
`define RFC_RC_MEM 6:5
`define RFC_RC_CAS2 4
`define RFC_RC_M9 3
`define RFC_RC_RFE 2
`define RFC_RC_RCY 0
`define RFC_TCS_FLAG 7
`define RFC_TCS_CMIE 6
`define RFC_TCS_CKS 5:3
`define RFC_MEM_BOTH 2'h3
`define RFC_MASK_128K 21'h01FFFF
`define RFC_MASK_2M 21'h1FFFFF
`define RFC_RESP_OK 2'h0
`define RFC_RESP_ERR 2'h2
`endif

// ---- rtl/rfc_pkg.sv ----
// Purpose: types of the refresh controller
// Assumes: nothing
// Notes: one-hot state codes
package rfc_pkg;
  typedef enum logic [2:0] {
    rfc_timer = 3'h1,
    rfc_dram = 3'h2,
    rfc_psram = 3'h4
  } rfc_mode_t;
  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_t1 = 9'h002,
    st_t2 = 9'h004,
    st_tw = 9'h008,
    st_t3 = 9'h010,
    st_r1 = 9'h020,
    st_r2 = 9'h040,
    st_r3 = 9'h080,
    st_sr = 9'h100
  } rfc_state_t;
endpackage

// ---- rtl/rfc_prescaler.sv ----
// Purpose: counter clock enable for the refresh timer
// Assumes: one system clock
// Notes: tick is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module rfc_prescaler (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  logic [11:0] div_q;

  function automatic logic [11:0] div_mask(input logic [2:0] s);
    unique case (s)
      3'h0: div_mask = 12'h000;
      3'h1: div_mask = 12'h001;
      3'h2: div_mask = 12'h007;
      3'h3: div_mask = 12'h01F;
      3'h4: div_mask = 12'h07F;
      3'h5: div_mask = 12'h1FF;
      3'h6: div_mask = 12'h7FF;
      3'h7: div_mask = 12'hFFF;
    endcase
  endfunction

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      div_q <= 12'h000;
    else if (!run_in)
      div_q <= 12'h000;
    else
      div_q <= div_q + 12'h001;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      tick_out <= 1'b0;
    else
      tick_out <= run_in && (sel_in != 3'h0) &&
        ((div_q & div_mask(sel_in)) == div_mask(sel_in));
  end

  property p_div2;
    @(posedge clk_in) disable iff (!resetn_in)
    tick_out && sel_in == 3'h1 && $stable(sel_in) |=> !tick_out;
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by 2 ticks twice in a row");
  property p_off;
    @(posedge clk_in) disable iff (!resetn_in)
    sel_in == 3'h0 |=> !tick_out;
  endproperty
  a_off: assert property (p_off)
    else $error("counter clock runs while disabled");
endmodule
`default_nettype wire

// ---- rtl/rfc_sequencer.sv ----
// Purpose: area 3 access and refresh strobe sequencer
// Assumes: 16-bit memory, one request at a time
// Notes: all strobes active low and registered
`timescale 1ns/1ps
`default_nettype none
module rfc_sequencer (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic dram_in,
  input wire logic psram_in,
  input wire logic cas2_in,
  input wire logic m9_in,
  input wire logic rfshe_in,
  input wire logic ast3_in,
  input wire logic [1:0] waits_in,
  input wire logic acc_req_in,
  input wire logic acc_write_in,
  input wire logic acc_upper_in,
  input wire logic acc_lower_in,
  input wire logic [20:0] acc_addr_in,
  input wire logic ref_req_in,
  input wire logic self_ref_in,
  output logic ras_n_out,
  output logic rd_n_out,
  output logic uw_n_out,
  output logic lw_n_out,
  output logic refresh_strobe_out_n_out,
  output logic [9:0] addr_out,
  output logic acc_done_out,
  output logic ref_done_out,
  output logic busy_out
);
  rfc_pkg::rfc_state_t st_q;
  logic [1:0] wc_q;
  logic wr_q;
  logic hi_q;
  logic lo_q;
  logic mem;

  assign mem = dram_in | psram_in;
  assign busy_out = !st_q[0];

  // {rd, upper, lower} strobes for both pin modes
  function automatic logic [2:0] strb(input logic c2, input logic cas,
      input logic we, input logic hi, input logic lo);
    if (c2)
      strb = {~we, ~(cas & hi), ~(cas & lo)};
    else
      strb = {~cas, ~(we & hi), ~(we & lo)};
  endfunction

  function automatic logic [9:0] mux(input logic [20:0] a,
      input logic m9, input logic row);
    if (m9)
      mux = row ? a[19:10] : {1'b0, a[9:1]};
    else
      mux = row ? a[18:9] : {2'b00, a[8:1]};
  endfunction

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= rfc_pkg::st_idle;
      {ras_n_out, rd_n_out, uw_n_out, lw_n_out, refresh_strobe_out_n_out} <= 5'h1F;
      addr_out <= 10'h000;
      {acc_done_out, ref_done_out} <= 2'b00;
      {wc_q, wr_q, hi_q, lo_q} <= 5'h00;
    end else begin
      acc_done_out <= 1'b0;
      ref_done_out <= 1'b0;
      unique case (st_q)
        rfc_pkg::st_idle: begin
          wc_q <= ast3_in ? waits_in : 2'b00;
          if (self_ref_in && mem) begin
            st_q <= rfc_pkg::st_sr;
            refresh_strobe_out_n_out <= 1'b0;
            {rd_n_out, uw_n_out, lw_n_out} <= strb(cas2_in, dram_in,
              1'b0, 1'b1, 1'b1);
          // a request still seen while done pulses is the one just served
          end else if (ref_req_in && mem && !ref_done_out) begin
            st_q <= rfc_pkg::st_r1;
            refresh_strobe_out_n_out <= !rfshe_in;
            {rd_n_out, uw_n_out, lw_n_out} <= strb(cas2_in, dram_in,
              1'b0, 1'b1, 1'b1);
          end else if (acc_req_in && mem && !acc_done_out) begin
            st_q <= rfc_pkg::st_t1;
            ras_n_out <= 1'b0;
            addr_out <= mux(acc_addr_in, m9_in, 1'b1);
            {wr_q, hi_q, lo_q} <= {acc_write_in, acc_upper_in,
              acc_lower_in};
          end
        end
        rfc_pkg::st_t1: begin
          st_q <= rfc_pkg::st_t2;
          addr_out <= mux(acc_addr_in, m9_in, 1'b0);
          {rd_n_out, uw_n_out, lw_n_out} <= strb(cas2_in & dram_in,
            dram_in | !wr_q, wr_q, hi_q, lo_q);
        end
        rfc_pkg::st_t2:
          st_q <= (wc_q != 2'b00) ? rfc_pkg::st_tw : rfc_pkg::st_t3;
        rfc_pkg::st_tw: begin
          wc_q <= wc_q - 2'b01;
          if (wc_q == 2'b01)
            st_q <= rfc_pkg::st_t3;
        end
        rfc_pkg::st_t3: begin
          st_q <= rfc_pkg::st_idle;
          {ras_n_out, rd_n_out, uw_n_out, lw_n_out} <= 4'hF;
          acc_done_out <= 1'b1;
        end
        rfc_pkg::st_r1: begin
          st_q <= rfc_pkg::st_r2;
          ras_n_out <= !dram_in;
        end
        rfc_pkg::st_r2: begin
          if (wc_q == 2'b00)
            st_q <= rfc_pkg::st_r3;
          else
            wc_q <= wc_q - 2'b01;
        end
        rfc_pkg::st_sr: begin
          ras_n_out <= !dram_in;
          if (!self_ref_in)
            st_q <= rfc_pkg::st_r3;
        end
        rfc_pkg::st_r3: begin
          st_q <= rfc_pkg::st_idle;
          {ras_n_out, rd_n_out, uw_n_out, lw_n_out} <= 4'hF;
          refresh_strobe_out_n_out <= 1'b1;
          ref_done_out <= 1'b1;
        end
        default: st_q <= rfc_pkg::st_idle;
      endcase
    end
  end

  property p_refresh_strobe_out_low;
    @(posedge clk_in) disable iff (!resetn_in)
    (st_q == rfc_pkg::st_r2 || st_q == rfc_pkg::st_r3) &&
      $past(rfshe_in, 2) && $past(st_q, 2) == rfc_pkg::st_idle |->
      !refresh_strobe_out_n_out;
  endproperty
  a_refresh_strobe_out_low: assert property (p_refresh_strobe_out_low)
    else $error("refresh strobe high during refresh");
  property p_three;
    @(posedge clk_in) disable iff (!resetn_in)
    st_q == rfc_pkg::st_t1 && (!ast3_in || waits_in == 2'b00) &&
      $past(st_q) == rfc_pkg::st_idle && $past(!ast3_in ||
      waits_in == 2'b00) |=> st_q == rfc_pkg::st_t2 ##1
      st_q == rfc_pkg::st_t3 ##1 acc_done_out;
  endproperty
  a_three: assert property (p_three)
    else $error("access is not three states long");
  property p_cas;
    @(posedge clk_in) disable iff (!resetn_in)
    st_q == rfc_pkg::st_t2 && dram_in && !cas2_in |-> !rd_n_out;
  endproperty
  a_cas: assert property (p_cas)
    else $error("column strobe missing in dual write enable mode");
  property p_ras;
    @(posedge clk_in) disable iff (!resetn_in)
    st_q == rfc_pkg::st_t2 |-> !ras_n_out;
  endproperty
  a_ras: assert property (p_ras)
    else $error("row strobe high in access");
endmodule
`default_nettype wire

// ---- rtl/rfc_top.sv ----
// Purpose: refresh controller and interval timer for area 3
// Assumes: AXI4-Lite slave, one 100 MHz clock, 16-bit memory
// Notes: byte address is index times four, data in bits 7:0
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "rfc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module rfc_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [17:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [17:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic module_stop_in,
  input wire logic standby_in,
  input wire logic mode_16m_in,
  input wire logic ast3_in,
  input wire logic [1:0] wait_states_in,
  input wire logic acc_req_in,
  input wire logic acc_write_in,
  input wire logic acc_upper_in,
  input wire logic acc_lower_in,
  input wire logic [23:0] acc_addr_in,
  output logic acc_done_out,
  output logic refresh_busy_out,
  output logic area3_select_n_out,
  output logic col_or_we_n_out,
  output logic upper_we_or_col_strobe_n_out,
  output logic lower_we_or_col_strobe_n_out,
  output logic refresh_strobe_n_out,
  output logic [9:0] dram_addr_out,
  output logic compare_match_interrupt_out
);
  logic [7:0] rc_q;
  logic [7:0] cnt_q;
  logic [7:0] cor_q;
  logic [2:0] cks_q;
  logic flag_q;
  logic cmie_q;
  logic flag_seen_q;
  logic ref_pend_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [15:0] waddr_q;
  logic [7:0] wdata_q;
  logic wbyte_q;
  logic irq_q;
  logic tick;
  logic match;
  logic wr_go;
  logic rd_go;
  logic lock;
  logic ref_done;
  logic [3:0] wsel;
  logic [3:0] rsel;
  logic [7:0] rdval;
  logic [20:0] mem_addr;
  rfc_pkg::rfc_mode_t mode;

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;
  assign compare_match_interrupt_out = irq_q;

  // one-hot select of rc, tcs, cnt, cor from a word index
  function automatic logic [3:0] reg_sel(input logic [15:0] idx);
    reg_sel = {idx == `RFC_IDX_COR, idx == `RFC_IDX_CNT,
      idx == `RFC_IDX_TCS, idx == `RFC_IDX_RC};
  endfunction

  function automatic rfc_pkg::rfc_mode_t mode_of(input logic [1:0] en);
    unique case (en)
      2'b00: mode_of = rfc_pkg::rfc_timer;
      2'b01: mode_of = rfc_pkg::rfc_dram;
      2'b10: mode_of = rfc_pkg::rfc_psram;
      default: mode_of = rfc_pkg::rfc_timer;
    endcase
  endfunction

  assign mode = mode_of(rc_q[`RFC_RC_MEM]);
  // timer-only bits freeze and cmie clears while a memory is attached
  assign lock = mode != rfc_pkg::rfc_timer;
  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  assign rd_go = s_axi_arvalid_in && arready_q;
  assign wsel = reg_sel(waddr_q) & {4{wr_go & wbyte_q}};
  assign rsel = reg_sel(s_axi_araddr_in[17:2]);
  assign match = tick && (cnt_q == cor_q);
  // address wraps inside the attached size
  assign mem_addr = acc_addr_in[20:0] & (mode_16m_in ?
    `RFC_MASK_2M : `RFC_MASK_128K);

  always_comb begin
    rdval = 8'h00;
    unique case (1'b1)
      rsel[0]: rdval = rc_q;
      rsel[1]: rdval = {flag_q, cmie_q, cks_q, `RFC_TCS_LOW};
      rsel[2]: rdval = cnt_q;
      rsel[3]: rdval = cor_q;
      default: rdval = 8'h00;
    endcase
  end

  // write address and data are taken in either order
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      awready_q <= 1'b1;
      waddr_q <= 16'h0000;
    end else if (s_axi_awvalid_in && awready_q) begin
      awready_q <= 1'b0;
      waddr_q <= s_axi_awaddr_in[17:2];
    end else if (bvalid_q && s_axi_bready_in) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wready_q <= 1'b1;
      wdata_q <= 8'h00;
      wbyte_q <= 1'b0;
    end else if (s_axi_wvalid_in && wready_q) begin
      wready_q <= 1'b0;
      wdata_q <= s_axi_wdata_in[7:0];
      wbyte_q <= s_axi_wstrb_in[0];
    end else if (bvalid_q && s_axi_bready_in) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RFC_RESP_OK;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (reg_sel(waddr_q) != 4'h0) ? `RFC_RESP_OK :
        `RFC_RESP_ERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `RFC_RESP_OK;
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= (rsel != 4'h0) ? `RFC_RESP_OK : `RFC_RESP_ERR;
      rdata_q <= {24'h000000, rdval};
    end else if (rvalid_q && s_axi_rready_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // bit 1 is never written, so it keeps reading as one
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rc_q <= `RFC_RC_RST;
    end else if (wsel[0]) begin
      rc_q[`RFC_RC_SRF] <= wdata_q[`RFC_RC_SRF];
      if (wdata_q[`RFC_RC_MEM] != `RFC_MEM_BOTH)
        rc_q[`RFC_RC_MEM] <= wdata_q[`RFC_RC_MEM];
      if (!lock) begin
        rc_q[`RFC_RC_CAS2] <= wdata_q[`RFC_RC_CAS2];
        rc_q[`RFC_RC_M9] <= wdata_q[`RFC_RC_M9];
        rc_q[`RFC_RC_RFE] <= wdata_q[`RFC_RC_RFE];
        rc_q[`RFC_RC_RCY] <= wdata_q[`RFC_RC_RCY];
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmie_q <= 1'b0;
      cks_q <= `RFC_CKS_RST;
    end else begin
      if (lock)
        cmie_q <= 1'b0;
      else if (wsel[1])
        cmie_q <= wdata_q[`RFC_TCS_CMIE];
      if (wsel[1] && !lock)
        cks_q <= wdata_q[`RFC_TCS_CKS];
    end
  end

  // a match in the clearing cycle keeps the flag set
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      flag_q <= 1'b0;
    else if (match)
      flag_q <= 1'b1;
    else if (wsel[1] && !wdata_q[`RFC_TCS_FLAG] && flag_seen_q)
      flag_q <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      flag_seen_q <= 1'b0;
    else if (wsel[1] || !flag_q)
      flag_seen_q <= 1'b0;
    else if (rd_go && rsel[1])
      flag_seen_q <= 1'b1;
  end

  // software write wins over a tick in the same cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      cnt_q <= `RFC_CNT_RST;
    else if (wsel[2] && !lock)
      cnt_q <= wdata_q;
    else if (match)
      cnt_q <= 8'h00;
    else if (tick)
      cnt_q <= cnt_q + 8'h01;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      cor_q <= `RFC_COR_RST;
    else if (wsel[3] && !lock)
      cor_q <= wdata_q;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      ref_pend_q <= 1'b0;
    else if (match && lock && rc_q[`RFC_RC_RCY])
      ref_pend_q <= 1'b1;
    else if (ref_done)
      ref_pend_q <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      irq_q <= 1'b0;
    else
      irq_q <= flag_q && cmie_q;
  end

  rfc_prescaler u_pre (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(!module_stop_in),
    .sel_in(cks_q),
    .tick_out(tick)
  );

  // acc_req_in stands for an access to area 3 only
  rfc_sequencer u_seq (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .dram_in(mode == rfc_pkg::rfc_dram),
    .psram_in(mode == rfc_pkg::rfc_psram),
    .cas2_in(rc_q[`RFC_RC_CAS2]),
    .m9_in(rc_q[`RFC_RC_M9]),
    .rfshe_in(rc_q[`RFC_RC_RFE]),
    .ast3_in(ast3_in),
    .waits_in(wait_states_in),
    .acc_req_in(acc_req_in),
    .acc_write_in(acc_write_in),
    .acc_upper_in(acc_upper_in),
    .acc_lower_in(acc_lower_in),
    .acc_addr_in(mem_addr),
    .ref_req_in(ref_pend_q && !module_stop_in),
    .self_ref_in(rc_q[`RFC_RC_SRF] && standby_in),
    .ras_n_out(area3_select_n_out),
    .rd_n_out(col_or_we_n_out),
    .uw_n_out(upper_we_or_col_strobe_n_out),
    .lw_n_out(lower_we_or_col_strobe_n_out),
    .refresh_strobe_out_n_out(refresh_strobe_n_out),
    .addr_out(dram_addr_out),
    .acc_done_out(acc_done_out),
    .ref_done_out(ref_done),
    .busy_out(refresh_busy_out)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_count_up;
    tick && !match && !wsel[2] |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("count did not step by one");
  property p_wrap;
    match && !wsel[2] |=> cnt_q == 8'h00 && flag_q;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count not restarted after match");
  property p_flag_keep;
    flag_q && !(wsel[1] && flag_seen_q) |=> flag_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("flag cleared without read then write");
  property p_irq;
    flag_q && cmie_q ##1 flag_q && cmie_q |-> compare_match_interrupt_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing after match");
  property p_stop;
    module_stop_in |=> !tick;
  endproperty
  a_stop: assert property (p_stop)
    else $error("timer runs while halted");
  property p_pair;
    rc_q[`RFC_RC_MEM] != `RFC_MEM_BOTH;
  endproperty
  a_pair: assert property (p_pair)
    else $error("both memory enables set");
  property p_locked;
    lock && wsel[3] |=> cor_q == $past(cor_q);
  endproperty
  a_locked: assert property (p_locked)
    else $error("constant written while memory attached");
  property p_read_cor;
    rd_go && rsel[3] |=> s_axi_rvalid_out &&
      s_axi_rdata_out[7:0] == $past(cor_q);
  endproperty
  a_read_cor: assert property (p_read_cor)
    else $error("constant read back wrong");
  property p_ref_req;
    match && lock && rc_q[`RFC_RC_RCY] |=> ref_pend_q;
  endproperty
  a_ref_req: assert property (p_ref_req)
    else $error("no refresh request after match");

  c_match: cover property (match);
  c_refresh: cover property (ref_done);
  c_access: cover property (acc_done_out);
  c_clear: cover property (flag_q ##1 !flag_q);
endmodule
`default_nettype wire

// ---- test/rfc_mem_model.sv ----
// Purpose: far-side DRAM watcher for area 3 strobes
// Assumes: dual write enable wiring, column strobe on the read-pin strobe
// Notes: counts column-before-row refreshes and bad refresh pins
`timescale 1ns/1ps
`default_nettype none
module rfc_mem_model (
  input wire logic clk_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic refresh_strobe_out_n_in,
  output var int refresh_count_out,
  output var int bad_refresh_strobe_out_out
);
  logic ras_q;
  initial begin
    ras_q = 1'b1;
    refresh_count_out = 0;
    bad_refresh_strobe_out_out = 0;
  end
  always @(posedge clk_in) begin
    ras_q <= ras_n_in;
    if (ras_q && !ras_n_in && !cas_n_in) begin
      refresh_count_out <= refresh_count_out + 1;
      if (refresh_strobe_out_n_in) begin
        bad_refresh_strobe_out_out <= bad_refresh_strobe_out_out + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: register, timer and area 3 strobe checks
// Assumes: AXI4-Lite master tasks, dual write enable DRAM wiring
// Notes: byte address is register index times four
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [17:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, v;
  logic awr, wrr, bv, arr, rv, done, busy, ras_n, col_n, uw_n, lw_n;
  logic rf_n, irq, stop = 0, ast3 = 0, req = 0, we = 0, stby = 0;
  logic [1:0] br, rr, ws = 0;
  logic [9:0] da;
  logic [3:0] seen;
  int refs, bad, n, fail_count = 0, checked = 0;
  localparam logic [17:0] RC = 18'h3FEB0, TCS = 18'h3FEB4;
  localparam logic [17:0] CNT = 18'h3FEB8, COR = 18'h3FEBC;
  rfc_top u_dut (.clk_in(clk), .resetn_in(rst_n), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rry), .module_stop_in(stop), .standby_in(stby),
    .mode_16m_in(1'b0), .ast3_in(ast3), .wait_states_in(ws),
    .acc_req_in(req), .acc_write_in(we), .acc_upper_in(1'b1),
    .acc_lower_in(1'b1), .acc_addr_in(24'h000246), .acc_done_out(done),
    .refresh_busy_out(busy), .area3_select_n_out(ras_n),
    .col_or_we_n_out(col_n), .upper_we_or_col_strobe_n_out(uw_n),
    .lower_we_or_col_strobe_n_out(lw_n), .refresh_strobe_n_out(rf_n),
    .dram_addr_out(da), .compare_match_interrupt_out(irq));
  rfc_mem_model u_mem (.clk_in(clk), .ras_n_in(ras_n), .cas_n_in(col_n),
    .refresh_strobe_out_n_in(rf_n), .refresh_count_out(refs), .bad_refresh_strobe_out_out(bad));
  initial begin
    forever #5 clk = ~clk;
  end
  task tally_and_finish;
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task tmo(input int k);
    if (k >= 60) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic wrt(input logic [17:0] a, input logic [7:0] d,
                     input logic [1:0] e);
    int k = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk);
      k++;
      if (awr) awv <= 0;
      if (wrr) wv <= 0;
    end while (bv !== 1'b1 && k < 60);
    bry <= 0;
    tmo(k);
    chk("bresp", 32'(e), 32'(br));
  endtask
  task automatic rdr(input string nm, input logic [17:0] a,
                     input logic [7:0] e, input logic [1:0] er);
    int k = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge clk);
      k++;
      if (arr) arv <= 0;
    end while (rv !== 1'b1 && k < 60);
    rry <= 0;
    tmo(k);
    chk("rresp", 32'(er), 32'(rr));
    chk(nm, {24'h0, e}, rd);
  endtask
  task automatic acc(input logic w);
    int k = 0;
    @(posedge clk);
    we <= w;
    req <= 1;
    seen = 4'hF;
    do begin
      @(posedge clk);
      k++;
      seen &= {ras_n, col_n, uw_n, lw_n};
    end while (done !== 1'b1 && k < 60);
    req <= 0;
    tmo(k);
    chk("strobes low", w ? 32'h0 : 32'h3, 32'(seen));
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rdr("rc", RC, 8'h02, 2'h0);
    rdr("tcs", TCS, 8'h07, 2'h0);
    rdr("cnt", CNT, 8'h00, 2'h0);
    rdr("cor", COR, 8'hFF, 2'h0);
    rdr("unmapped", 18'h3FEC0, 8'h00, 2'h2);
    wrt(18'h3FEC0, 8'h5A, 2'h2);
    wrt(COR, 8'h03, 2'h0);
    wrt(TCS, 8'h48, 2'h0);
    for (n = 0; n < 60 && irq !== 1'b1; n++) @(posedge clk);
    tmo(n);
    wrt(TCS, 8'h40, 2'h0);
    rdr("flag kept", TCS, 8'hC7, 2'h0);
    wrt(TCS, 8'h40, 2'h0);
    rdr("flag cleared", TCS, 8'h47, 2'h0);
    chk("irq", 32'h0, 32'(irq));
    wrt(CNT, 8'h10, 2'h0);
    repeat (20) @(posedge clk);
    rdr("cnt held", CNT, 8'h10, 2'h0);
    wrt(COR, 8'h04, 2'h0);
    wrt(CNT, 8'h00, 2'h0);
    wrt(TCS, 8'h08, 2'h0);
    wrt(RC, 8'h05, 2'h0);
    wrt(RC, 8'h25, 2'h0);
    rdr("rc dram", RC, 8'h27, 2'h0);
    wrt(COR, 8'h55, 2'h0);
    rdr("cor locked", COR, 8'h04, 2'h0);
    acc(1'b1);
    chk("column address", 32'h23, 32'(da));
    ast3 <= 1;
    ws <= 2'h2;
    acc(1'b0);
    repeat (100) @(posedge clk);
    chk("refreshes", 32'h1, 32'(refs > 0));
    chk("refresh pin", 32'h0, 32'(bad));
    stop <= 1;
    repeat (30) @(posedge clk);
    v = 32'(refs);
    repeat (200) @(posedge clk);
    chk("halted", v, 32'(refs));
    wrt(RC, 8'hA5, 2'h0);
    stby <= 1;
    repeat (10) @(posedge clk);
    chk("self refresh busy", 32'h1, 32'(busy));
    chk("self refresh pin", 32'h0, 32'(rf_n));
    stby <= 0;
    repeat (10) @(posedge clk);
    chk("standby exit", 32'h0, 32'(busy));
    chk("self refresh entry", v + 32'h1, 32'(refs));
    tally_and_finish();
  end
endmodule
`default_nettype wire
